/* File: bench/hsw_prog_model.sv */
`timescale 1ns/100ps
`default_nettype none
module hsw_prog_model
#(
  parameter int P = 32,
  parameter int WAIT_CYC = 30,
  parameter int PROG_CYC = 60
)
(
  input wire logic clk,
  input wire logic out_pin,
  output logic sup_hi,
  output logic prog_sup
);
  initial {sup_hi, prog_sup} = 2'b00;

  task automatic bit_out(input logic b);
    repeat (P * 65 / 100) @(posedge clk);
    if (b)
      sup_hi <= ~sup_hi;
    repeat (P - P * 65 / 100) @(posedge clk);
    sup_hi <= ~sup_hi;
  endtask

  // bad flips command, address and data parity, one bit each
  task automatic xfer(input logic [2:0] cmd, input logic [3:0] adr,
    input logic [13:0] data, input logic [2:0] bad, output logic ack,
    output int len, output logic [14:0] rd);
    logic [23:0] f;
    int n;
    logic a;
    f = {cmd, ^(~cmd) ^ bad[2], adr, ^(~adr) ^ bad[1], data,
      ~^(~data) ^ bad[0]};
    n = (cmd == 3'h3) ? 24 : 9;
    ack = 1'b0;
    len = 0;
    rd = '0;
    @(posedge clk);
    sup_hi <= ~sup_hi;
    bit_out(1'b0);
    for (int i = 23; i > 23 - n; i--)
      bit_out(f[i]);
    n = 0;
    while (out_pin !== 1'b0 && n < 4 * P)
    begin
      @(posedge clk);
      n++;
    end
    if (out_pin === 1'b0)
    begin
      ack = 1'b1;
      while (out_pin === 1'b0 && len < 1000)
      begin
        @(posedge clk);
        len++;
      end
      // a bit is a one when the level differs between 10% and 90%
      if (cmd == 3'h2)
        for (int i = 14; i >= 0; i--)
        begin
          repeat (len / 10) @(posedge clk);
          a = out_pin;
          repeat (len * 8 / 10) @(posedge clk);
          rd[i] = a ^ out_pin;
          repeat (len - len / 10 - len * 8 / 10) @(posedge clk);
        end
      repeat (2 * len) @(posedge clk);
      // delay and burn time shortened so the run stays short
      if (cmd == 3'h4)
      begin
        repeat (WAIT_CYC) @(posedge clk);
        prog_sup <= 1'b1;
        repeat (PROG_CYC) @(posedge clk);
        prog_sup <= 1'b0;
        repeat (4) @(posedge clk);
      end
    end
  endtask
endmodule
`default_nettype wire

/* File: bench/tb_hsw_prog_link.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_hsw_prog_link;
  import hsw_pkg::*;
  localparam int OUT_T = 40;
  typedef struct packed {
    logic [3:0] adr;
    logic [3:0] w;
    logic [13:0] wd;
  } hsw_row_s;
  hsw_row_s rows [7] = '{
    '{4'h1, 4'hA, 14'h3ABC}, '{4'h2, 4'hB, 14'h1555},
    '{4'h3, 4'hB, 14'h3C0F}, '{4'h4, 4'hE, 14'h2AA5},
    '{4'h5, 4'h6, 14'h3F2B}, '{4'hB, 4'h6, 14'h0031},
    '{4'hC, 4'h5, 14'h3FF3}};
  logic [2:0] bad_cmd [3] = '{3'h0, 3'h1, 3'h6};
  logic [2:0] bad_par [3] = '{3'h4, 3'h2, 3'h1};
  logic [9:0] off_thr;
  logic [10:0] on_thr, quiesc_off;
  logic [5:0] tc_lin;
  logic [4:0] tc_quad;
  logic clk, rst_b, pwr_on, sup_hi, prog_sup, out_pin;
  logic analog_mode, lock_cell, ack;
  logic [13:0] adc_value, mag_gain, m, e;
  logic [2:0] range_sel, filter_sel;
  logic [14:0] rd;
  int len;
  int err_count = 0;
  int samples_checked = 0;

  hsw_prog_link #(.OUT_CYC(OUT_T)) hsw_prog_link_i (.clk(clk),
    .rst_b(rst_b), .pwr_on(pwr_on), .sup_hi(sup_hi), .prog_sup(prog_sup),
    .adc_value(adc_value), .out_pin(out_pin), .analog_mode(analog_mode),
    .lock_cell(lock_cell), .off_thr(off_thr), .on_thr(on_thr),
    .quiesc_off(quiesc_off),
    .mag_gain(mag_gain), .range_sel(range_sel), .filter_sel(filter_sel),
    .tc_lin(tc_lin), .tc_quad(tc_quad));
  hsw_prog_model hsw_prog_model_i (.clk(clk), .out_pin(out_pin),
    .sup_hi(sup_hi), .prog_sup(prog_sup));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // a power cycle reloads RAM and the lock state from the cells
  task automatic pwr_cycle();
    pwr_on <= 1'b0;
    repeat (3) @(posedge clk);
    pwr_on <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  task automatic send(input logic [2:0] c, input logic [3:0] a,
    input logic [13:0] d);
    hsw_prog_model_i.xfer(c, a, d, 3'h0, ack, len, rd);
  endtask

  initial
  begin
    repeat (100000) @(posedge clk);
    err_count++;
    results();
  end

  initial
  begin
    rst_b = 1'b0;
    pwr_on = 1'b0;
    adc_value = 14'h2001;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    check({15'h0, out_pin}, 16'h0001);
    check({2'h0, mag_gain}, 16'h0000);
    check({14'h0, analog_mode, lock_cell}, 16'h0000);
    pwr_on <= 1'b1;
    repeat (3) @(posedge clk);
    $display("reset test done");
    foreach (rows[k])
    begin
      m = 14'h3FFF >> (14 - rows[k].w);
      e = (rows[k].wd & m) << (14 - rows[k].w);
      send(CMD_WRITE, rows[k].adr, rows[k].wd);
      check({15'h0, ack}, 16'h0001);
      send(CMD_READ, rows[k].adr, 14'h0000);
      check({2'h0, rd[14:1]}, {2'h0, e});
      check({15'h0, rd[0]}, {15'h0, ~^(~e)});
      check({15'h0, len >= OUT_T - 1 && len <= OUT_T + 1}, 16'h1);
    end
    check({10'h0, filter_sel, range_sel}, 16'h002B);
    check({2'h0, mag_gain}, 16'h2AA5);
    check({6'h0, off_thr}, 16'h02BC);
    check({5'h0, on_thr}, 16'h0555);
    check({5'h0, quiesc_off}, 16'h040F);
    check({10'h0, tc_lin}, 16'h0031);
    check({11'h0, tc_quad}, 16'h0013);
    $display("register table test done");
    send(CMD_WRITE, 4'h7, 14'h0123);
    check({15'h0, ack}, 16'h0001);
    send(CMD_READ, 4'h7, 14'h0000);
    check({1'b0, rd}, {1'b0, 14'h2001, 1'b1});
    adc_value <= 14'h1FFE;
    send(CMD_READ, 4'h7, 14'h0000);
    check({1'b0, rd}, {1'b0, 14'h1FFE, 1'b1});
    $display("conversion test done");
    foreach (bad_par[k])
    begin
      hsw_prog_model_i.xfer(CMD_WRITE, 4'h4, 14'h0111, bad_par[k], ack, len,
        rd);
      check({15'h0, ack}, 16'h0000);
    end
    foreach (bad_cmd[k])
    begin
      send(bad_cmd[k], 4'h4, 14'h0111);
      check({15'h0, ack}, 16'h0000);
    end
    check({2'h0, mag_gain}, 16'h2AA5);
    $display("refusal test done");
    send(CMD_ERASE, 4'h9, 14'h0000);
    check({15'h0, ack}, 16'h0001);
    send(CMD_PROG, 4'h0, 14'h0000);
    check({15'h0, ack}, 16'h0001);
    send(CMD_WRITE, 4'h4, 14'h0111);
    pwr_cycle();
    check({2'h0, mag_gain}, 16'h2AA5);
    send(CMD_ERASE, 4'h4, 14'h0000);
    pwr_cycle();
    check({2'h0, mag_gain}, 16'h0000);
    $display("nonvolatile test done");
    send(CMD_LOCK, 4'h6, 14'h0000);
    check({14'h0, ack, lock_cell}, 16'h0003);
    check({15'h0, analog_mode}, 16'h0000);
    send(CMD_ERASE, 4'h0, 14'h0000);
    check({15'h0, lock_cell}, 16'h0001);
    pwr_cycle();
    check({15'h0, analog_mode}, 16'h0001);
    send(CMD_WRITE, 4'h4, 14'h0111);
    check({15'h0, ack}, 16'h0000);
    $display("lock test done");
    rst_b <= 1'b0;
    @(posedge clk);
    check({13'h0, out_pin, analog_mode, lock_cell}, 16'h0004);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    send(CMD_WRITE, 4'h4, 14'h0123);
    check({15'h0, ack}, 16'h0001);
    check({2'h0, mag_gain}, 16'h0123);
    $display("mid-run reset test done");
    results();
  end
endmodule
`default_nettype wire

/* File: include/hsw_pkg.sv */
`default_nettype none
package hsw_pkg;
  localparam int CLK_FREQ_KHZ = 50000;
  // output_bit_period, nominal figure in microseconds
  localparam int OUT_BIT_PERIOD_US = 3000;
  localparam int OUT_BIT_CYC = OUT_BIT_PERIOD_US * CLK_FREQ_KHZ / 1000;
  // a logical 1 on the output toggles at this percentage of the period
  localparam int OUT_ONE_PCT = 65;
  localparam int CNT_W = 18;
  localparam int DATA_W = 14;
  localparam int FRAME_W = 24;
  localparam logic [4:0] HDR_BITS = 5'h09;
  localparam logic [4:0] WR_BITS = 5'h18;
  localparam logic [4:0] ACK_ONLY = 5'h01;
  localparam logic [4:0] ACK_DATA = 5'h10;
  localparam logic [2:0] CMD_READ = 3'h2;
  localparam logic [2:0] CMD_WRITE = 3'h3;
  localparam logic [2:0] CMD_PROG = 3'h4;
  localparam logic [2:0] CMD_ERASE = 3'h5;
  localparam logic [2:0] CMD_LOCK = 3'h7;
  localparam logic [3:0] ADR_OFF_THR = 4'h1;
  localparam logic [3:0] ADR_ON_THR = 4'h2;
  localparam logic [3:0] ADR_QOFF = 4'h3;
  localparam logic [3:0] ADR_GAIN = 4'h4;
  localparam logic [3:0] ADR_RANGE = 4'h5;
  localparam logic [3:0] ADR_LOCK = 4'h6;
  localparam logic [3:0] ADR_CONV = 4'h7;
  localparam logic [3:0] ADR_TC_LIN = 4'hB;
  localparam logic [3:0] ADR_TC_QUAD = 4'hC;
  localparam logic [13:0] RAM_RESET = 14'h0000;

  typedef enum logic [2:0] {ST_IDLE, ST_SYNC, ST_BITS, ST_EXEC, ST_REPLY}
    hsw_state_e;

  function automatic logic [3:0] hsw_width(input logic [3:0] adr);
    case (adr)
      ADR_OFF_THR: hsw_width = 4'hA;
      ADR_ON_THR: hsw_width = 4'hB;
      ADR_QOFF: hsw_width = 4'hB;
      ADR_GAIN: hsw_width = 4'hE;
      ADR_RANGE: hsw_width = 4'h6;
      ADR_LOCK: hsw_width = 4'h1;
      ADR_CONV: hsw_width = 4'hE;
      ADR_TC_LIN: hsw_width = 4'h6;
      ADR_TC_QUAD: hsw_width = 4'h5;
      default: hsw_width = 4'h0;
    endcase
  endfunction

  function automatic logic hsw_writable(input logic [3:0] adr);
    hsw_writable = (hsw_width(adr) != 4'h0) && (adr != ADR_LOCK)
      && (adr != ADR_CONV);
  endfunction
endpackage
`default_nettype wire

/* File: verilog/hsw_prog_link.sv */
`timescale 1ns/100ps
`default_nettype none
module hsw_prog_link
  import hsw_pkg::*;
#(
  parameter int OUT_CYC = OUT_BIT_CYC
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic pwr_on,
  input wire logic sup_hi,
  input wire logic prog_sup,
  input wire logic [13:0] adc_value,
  output logic out_pin,
  output logic analog_mode,
  output logic lock_cell,
  output logic [9:0] off_thr,
  output logic [10:0] on_thr,
  output logic [10:0] quiesc_off,
  output logic [13:0] mag_gain,
  output logic [2:0] range_sel,
  output logic [2:0] filter_sel,
  output logic [5:0] tc_lin,
  output logic [4:0] tc_quad
);
  localparam logic [CNT_W-1:0] OUT_LAST = CNT_W'(OUT_CYC - 1);
  localparam logic [CNT_W-1:0] OUT_ONE = CNT_W'(OUT_CYC * OUT_ONE_PCT / 100);
  localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

  hsw_state_e st_r;
  logic sup_d_r;
  logic pwr_d_r;
  logic prog_d_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] per_r;
  logic [CNT_W-1:0] tcnt_r;
  logic mid_r;
  logic [4:0] nbits_r;
  logic [FRAME_W-1:0] sh_r;
  logic [15:0] tx_sh_r;
  logic [4:0] tx_left_r;
  logic out_r;
  logic [13:0] ram_r [0:15];
  logic [13:0] nv_r [0:15];
  logic [13:0] conv_r;
  logic lock_cell_r;
  logic locked_r;
  logic armed_r;

  logic edge_sup;
  logic pwr_rise;
  logic prog_rise;
  logic [CNT_W-1:0] mid_thr;
  logic [FRAME_W-1:0] frame;
  logic [2:0] cmd;
  logic [3:0] adr;
  logic [13:0] dat;
  logic cmd_known;
  logic ok;
  logic tx_done;
  logic [13:0] rd_val;
  logic [13:0] rd_word;
  logic [13:0] wr_mask;

  assign edge_sup = sup_hi ^ sup_d_r;
  assign pwr_rise = pwr_on & ~pwr_d_r;
  assign prog_rise = prog_sup & ~prog_d_r;
  // mid-bit toggles land by 80%, bit ends at 100%: split at 87.5%
  assign mid_thr = per_r - (per_r >> 3);

  always_comb
  begin
    // header-only telegrams are left-justified so fields sit in one place
    if (nbits_r == WR_BITS)
      frame = sh_r;
    else
      frame = {sh_r[8:0], 15'h0000};
    cmd = frame[23:21];
    adr = frame[19:16];
    dat = frame[14:1];
    cmd_known = (cmd == CMD_READ) || (cmd == CMD_WRITE)
      || (cmd == CMD_PROG) || (cmd == CMD_ERASE) || (cmd == CMD_LOCK);
    ok = (st_r == ST_EXEC) && !locked_r && cmd_known
      && (frame[20] == ^(~cmd))
      && (frame[15] == ^(~adr))
      && ((cmd != CMD_WRITE) || (frame[0] == ~^(~dat)));
  end

  always_comb
  begin
    if (adr == ADR_CONV)
      rd_val = conv_r;
    else
      rd_val = ram_r[adr];
    rd_word = 14'(rd_val << (4'hE - hsw_width(adr)));
    wr_mask = 14'((15'h0001 << hsw_width(adr)) - 15'h0001);
  end

  assign tx_done = (st_r == ST_REPLY) && (tcnt_r == OUT_LAST)
    && (tx_left_r == ACK_ONLY);

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_r <= ST_IDLE;
      sup_d_r <= 1'b0;
      cnt_r <= '0;
      per_r <= '0;
      mid_r <= 1'b0;
      nbits_r <= 5'h00;
      sh_r <= '0;
    end
    else
    begin
      sup_d_r <= sup_hi;
      case (st_r)
        ST_IDLE:
        begin
          cnt_r <= '0;
          // ignore the programming level and the stale edge after reset
          if (edge_sup && !prog_sup && pwr_d_r)
            st_r <= ST_SYNC;
        end
        ST_SYNC:
        begin
          cnt_r <= cnt_r + 1'b1;
          if (edge_sup)
          begin
            per_r <= cnt_r;
            cnt_r <= '0;
            nbits_r <= 5'h00;
            mid_r <= 1'b0;
            st_r <= ST_BITS;
          end
          else if (cnt_r == CNT_MAX)
            st_r <= ST_IDLE;
        end
        ST_BITS:
        begin
          cnt_r <= cnt_r + 1'b1;
          if (edge_sup && (cnt_r < mid_thr))
            mid_r <= 1'b1;
          else if (edge_sup)
          begin
            sh_r <= {sh_r[FRAME_W-2:0], mid_r};
            nbits_r <= nbits_r + 5'h01;
            cnt_r <= '0;
            mid_r <= 1'b0;
            if ((nbits_r + 5'h01 == HDR_BITS && sh_r[7:5] != CMD_WRITE)
              || (nbits_r + 5'h01 == WR_BITS))
              st_r <= ST_EXEC;
          end
          else if ({1'b0, cnt_r} > {per_r, 1'b0})
            st_r <= ST_IDLE;
        end
        ST_EXEC:
          st_r <= ok ? ST_REPLY : ST_IDLE;
        ST_REPLY:
          if (tx_done)
            st_r <= ST_IDLE;
        default:
          st_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      out_r <= 1'b1;
      tcnt_r <= '0;
      tx_sh_r <= 16'h0000;
      tx_left_r <= 5'h00;
    end
    else if (ok)
    begin
      out_r <= 1'b0;
      tcnt_r <= '0;
      if (cmd == CMD_READ)
      begin
        tx_sh_r <= {1'b0, rd_word, ~^(~rd_word)};
        tx_left_r <= ACK_DATA;
      end
      else
      begin
        tx_sh_r <= 16'h0000;
        tx_left_r <= ACK_ONLY;
      end
    end
    else if (st_r == ST_REPLY)
    begin
      tcnt_r <= tcnt_r + 1'b1;
      if (tcnt_r == OUT_ONE && tx_sh_r[15])
        out_r <= ~out_r;
      if (tcnt_r == OUT_LAST)
      begin
        // the last edge may be absorbed if the line already sits idle
        out_r <= (tx_left_r == ACK_ONLY) ? 1'b1 : ~out_r;
        tcnt_r <= '0;
        tx_sh_r <= {tx_sh_r[14:0], 1'b0};
        tx_left_r <= tx_left_r - 5'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < 16; i++)
        ram_r[i] <= RAM_RESET;
    end
    else if (pwr_rise)
    begin
      for (int i = 0; i < 16; i++)
        ram_r[i] <= nv_r[i];
    end
    else if (ok && cmd == CMD_WRITE && hsw_writable(adr))
      ram_r[adr] <= dat & wr_mask;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < 16; i++)
        nv_r[i] <= RAM_RESET;
      armed_r <= 1'b0;
      prog_d_r <= 1'b0;
    end
    else
    begin
      prog_d_r <= prog_sup;
      if (ok)
        armed_r <= (cmd == CMD_PROG);
      else if (armed_r && prog_rise)
        armed_r <= 1'b0;
      // address is ignored: erase and program act on every register
      if (ok && cmd == CMD_ERASE)
      begin
        for (int i = 0; i < 16; i++)
          nv_r[i] <= RAM_RESET;
      end
      else if (armed_r && prog_rise)
      begin
        for (int i = 0; i < 16; i++)
          nv_r[i] <= ram_r[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      lock_cell_r <= 1'b0;
      locked_r <= 1'b0;
      pwr_d_r <= 1'b0;
      conv_r <= 14'h0000;
    end
    else
    begin
      pwr_d_r <= pwr_on;
      conv_r <= adc_value;
      if (ok && cmd == CMD_LOCK)
        lock_cell_r <= 1'b1;
      // the lock cell is only looked at on a power-up
      if (pwr_rise)
        locked_r <= lock_cell_r;
    end
  end

  assign out_pin = out_r;
  assign analog_mode = locked_r;
  assign lock_cell = lock_cell_r;
  assign off_thr = ram_r[ADR_OFF_THR][9:0];
  assign on_thr = ram_r[ADR_ON_THR][10:0];
  assign quiesc_off = ram_r[ADR_QOFF][10:0];
  assign mag_gain = ram_r[ADR_GAIN];
  assign range_sel = ram_r[ADR_RANGE][2:0];
  assign filter_sel = ram_r[ADR_RANGE][5:3];
  assign tc_lin = ram_r[ADR_TC_LIN][5:0];
  assign tc_quad = ram_r[ADR_TC_QUAD][4:0];

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence ack_start;
    ok ##1 (st_r == ST_REPLY) && !out_r;
  endsequence

  a_ack_low_start: assert property (ok |-> ack_start)
    else $error("acknowledge did not start low");
  a_ack_holds: assert property (ok |=> !out_r [*8])
    else $error("acknowledge pulse broke early");
  a_read_length: assert property (ok && cmd == CMD_READ |=>
    tx_left_r == ACK_DATA && !tx_sh_r[15])
    else $error("read reply length wrong");
  a_data_parity: assert property (ok && cmd == CMD_READ |=>
    tx_sh_r[0] == ~^(~tx_sh_r[14:1]))
    else $error("reply data parity wrong");
  a_sync_period: assert property (st_r == ST_SYNC && edge_sup |=>
    per_r == $past(cnt_r) && st_r == ST_BITS)
    else $error("sync length not captured");
  a_cmd_parity: assert property ((st_r == ST_EXEC)
    && (frame[20] != ^(~cmd)) |=> st_r == ST_IDLE && out_r)
    else $error("bad command parity answered");
  a_adr_parity: assert property ((st_r == ST_EXEC)
    && (frame[15] != ^(~adr)) |=> st_r == ST_IDLE)
    else $error("bad address parity answered");
  a_wr_trailing: assert property (ok && cmd == CMD_WRITE
    && adr == ADR_TC_LIN |=> ram_r[ADR_TC_LIN] == {8'h00, $past(dat[5:0])})
    else $error("narrow write not from trailing bits");
  a_erase_keeps: assert property (ok && cmd == CMD_ERASE |=>
    nv_r[ADR_GAIN] == 14'h0000 && lock_cell_r == $past(lock_cell_r))
    else $error("erase wrong");
  a_lock_latent: assert property (ok && cmd == CMD_LOCK && !pwr_rise
    |=> lock_cell_r && locked_r == $past(locked_r))
    else $error("lock acted before power-up");
  a_mid_one: assert property (st_r == ST_BITS && edge_sup
    && cnt_r < mid_thr |=> mid_r && nbits_r == $past(nbits_r))
    else $error("mid-bit edge not taken as one");
endmodule
`default_nettype wire
